// ---- core/cem_regs.sv ----
// two control registers: standby low-power selects, and channel enables with modes
// assumes a byte register port from the serial slave (one-cycle strobes), enable pin
// asynchronous, and per-channel delay-done levels from the sequencer outside
`timescale 1ns/1ps
`default_nettype none
module cem_regs
    import cem_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     variant_alkaline,
    input  wire logic                     en_pin,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    input  wire logic [CEM_NUM_GATED-1:0] delay_done,
    output logic                          delay_start,
    output logic      [CEM_NUM_GATED-1:0] chan_run,
    output logic                          ch1_mode_select,
    output logic                          ch10_mode_select,
    output logic                          ch1_standby_low_power,
    output logic                          ch10_standby_low_power
);
    cem_state_t r;
    cem_state_t next_r;
    logic       en_rise;
    logic       en_low;

    assign en_rise = r.en_q2 & ~r.en_prev;
    assign en_low  = ~r.en_q2;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_r         = r;
        next_r.en_q1   = en_pin;
        next_r.en_q2   = r.en_q1;
        next_r.en_prev = r.en_q2;
        // strap caught after reset release, never inside the reset branch
        if (!r.strap_done)
        begin
            next_r.strap_done = 1'b1;
            next_r.standby_pfm_select[CEM_BIT_CH1_STBY] = variant_alkaline;
        end
        if (reg_wr && reg_addr == CEM_ADDR_STANDBY)
        begin
            next_r.standby_pfm_select = reg_wdata;
        end
        else if (reg_wr && reg_addr == CEM_ADDR_CHAN_EN)
        begin
            next_r.channel_enable_mode = reg_wdata;
        end
        // pin low wins over a write in the same cycle
        if (en_low)
        begin
            next_r.channel_enable_mode = CEM_RST_CHAN_EN;
        end
        if (reg_rd && reg_addr == CEM_ADDR_STANDBY)
        begin
            next_r.rd_data = r.standby_pfm_select;
        end
        else if (reg_rd && reg_addr == CEM_ADDR_CHAN_EN)
        begin
            next_r.rd_data = r.channel_enable_mode;
        end
        else if (reg_rd)
        begin
            next_r.rd_data = 8'h00;
        end
        // a channel runs only with pin high, its bit set and its delay over
        if (en_low)
        begin
            next_r.run = '0;
        end
        else
        begin
            next_r.run = r.run | (r.channel_enable_mode[CEM_BIT_LSW_ON:CEM_BIT_CH8_ON] & delay_done);
            next_r.run = next_r.run & r.channel_enable_mode[CEM_BIT_LSW_ON:CEM_BIT_CH8_ON];
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r                     <= '0;
            r.standby_pfm_select  <= CEM_RST_STANDBY;
            r.channel_enable_mode <= CEM_RST_CHAN_EN;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign reg_rdata              = r.rd_data;
    assign delay_start            = en_rise;
    assign chan_run               = r.run;
    assign ch1_mode_select        = r.channel_enable_mode[CEM_BIT_CH1_MODE];
    assign ch10_mode_select       = r.channel_enable_mode[CEM_BIT_CH10_MODE];
    assign ch1_standby_low_power  = r.standby_pfm_select[CEM_BIT_CH1_STBY];
    assign ch10_standby_low_power = r.standby_pfm_select[CEM_BIT_CH10_STBY];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_pin_low_resets;
        @(posedge clk_sys) disable iff (rst)
        !r.en_q2 |=> r.channel_enable_mode == CEM_RST_CHAN_EN;
    endproperty
    a_pin_low_resets: assert property (p_pin_low_resets) else $error("enable byte not reset while pin low");

    property p_no_run_low;
        @(posedge clk_sys) disable iff (rst)
        !r.en_q2 |=> chan_run == '0;
    endproperty
    a_no_run_low: assert property (p_no_run_low) else $error("channel running while pin low");

    property p_run_needs_bit;
        @(posedge clk_sys) disable iff (rst)
        chan_run != '0 |-> (chan_run & ~$past(r.channel_enable_mode[CEM_BIT_LSW_ON:CEM_BIT_CH8_ON])) == '0;
    endproperty
    a_run_needs_bit: assert property (p_run_needs_bit) else $error("disabled channel running");

    property p_run_after_done;
        @(posedge clk_sys) disable iff (rst)
        (r.en_q2 && delay_done[0] && r.channel_enable_mode[CEM_BIT_CH8_ON]) |=> chan_run[0];
    endproperty
    a_run_after_done: assert property (p_run_after_done) else $error("channel 8 did not start");

    property p_stby_write;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == CEM_ADDR_STANDBY && r.strap_done) |=> ch1_standby_low_power == $past(reg_wdata[1])
            && ch10_standby_low_power == $past(reg_wdata[0]);
    endproperty
    a_stby_write: assert property (p_stby_write) else $error("standby write lost");

    property p_mode_write;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == CEM_ADDR_CHAN_EN && r.en_q2) |=> ch1_mode_select == $past(reg_wdata[7])
            && ch10_mode_select == $past(reg_wdata[0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_strap;
        @(posedge clk_sys)
        $fell(rst) |=> ch1_standby_low_power == $past(variant_alkaline);
    endproperty
    a_strap: assert property (p_strap) else $error("variant default wrong");

    property p_read_back;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == CEM_ADDR_STANDBY) |=> reg_rdata == $past(r.standby_pfm_select);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong");

    property p_read_back_en;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == CEM_ADDR_CHAN_EN) |=> reg_rdata == $past(r.channel_enable_mode);
    endproperty
    a_read_back_en: assert property (p_read_back_en) else $error("enable byte read wrong");

    // the pulse starts the outside delay timers, so it must follow the synced edge exactly
    property p_start_on_rise;
        @(posedge clk_sys) disable iff (rst)
        delay_start == $rose(r.en_q2);
    endproperty
    a_start_on_rise: assert property (p_start_on_rise) else $error("delay start pulse wrong");

    property p_lsw_start;
        @(posedge clk_sys) disable iff (rst)
        (r.en_q2 && delay_done[CEM_BIT_LSW_ON - CEM_BIT_CH8_ON] && r.channel_enable_mode[CEM_BIT_LSW_ON])
            |=> chan_run[CEM_BIT_LSW_ON - CEM_BIT_CH8_ON];
    endproperty
    a_lsw_start: assert property (p_lsw_start) else $error("load switch did not start");

    // the load switch channel must never beat its own delay timer
    property p_wait_for_delay;
        @(posedge clk_sys) disable iff (rst)
        (!delay_done[CEM_BIT_LSW_ON - CEM_BIT_CH8_ON] && !chan_run[CEM_BIT_LSW_ON - CEM_BIT_CH8_ON])
            |=> !chan_run[CEM_BIT_LSW_ON - CEM_BIT_CH8_ON];
    endproperty
    a_wait_for_delay: assert property (p_wait_for_delay) else $error("load switch started early");

    property p_run_holds;
        @(posedge clk_sys) disable iff (rst)
        (chan_run[0] && r.en_q2 && r.channel_enable_mode[CEM_BIT_CH8_ON]) |=> chan_run[0];
    endproperty
    a_run_holds: assert property (p_run_holds) else $error("running channel dropped");

    property p_bit_off_stops;
        @(posedge clk_sys) disable iff (rst)
        !r.channel_enable_mode[CEM_BIT_CH4_ON] |=> !chan_run[CEM_BIT_CH4_ON - CEM_BIT_CH8_ON];
    endproperty
    a_bit_off_stops: assert property (p_bit_off_stops) else $error("channel 4 runs while disabled");

    property p_write_refused_low;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == CEM_ADDR_CHAN_EN && !r.en_q2) |=> r.channel_enable_mode == CEM_RST_CHAN_EN;
    endproperty
    a_write_refused_low: assert property (p_write_refused_low) else $error("enable write taken while pin low");

    property p_standby_holds;
        @(posedge clk_sys) disable iff (rst)
        (r.strap_done && !(reg_wr && reg_addr == CEM_ADDR_STANDBY)) |=> $stable(r.standby_pfm_select);
    endproperty
    a_standby_holds: assert property (p_standby_holds) else $error("standby byte changed unasked");
endmodule : cem_regs
`default_nettype wire

// ---- core/cem_pkg.sv ----
// package for the channel enable and mode register pair
// assumes one 100 MHz clock and a byte-wide register port from the serial slave
package cem_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CEM_ADDR_STANDBY  = 8'h0D;
    localparam logic [7:0] CEM_ADDR_CHAN_EN  = 8'h0E;
    localparam logic [7:0] CEM_RST_STANDBY   = 8'h00;
    localparam logic [7:0] CEM_RST_CHAN_EN   = 8'hA1;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CEM_BIT_CH10_STBY = 0;
    localparam int CEM_BIT_CH1_STBY  = 1;
    localparam int CEM_BIT_CH10_MODE = 0;
    localparam int CEM_BIT_CH8_ON    = 1;
    localparam int CEM_BIT_CH4_ON    = 5;
    localparam int CEM_BIT_LSW_ON    = 6;
    localparam int CEM_BIT_CH1_MODE  = 7;
    localparam int CEM_NUM_GATED     = 6;
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] standby_pfm_select;
        logic [7:0] channel_enable_mode;
        logic [7:0] rd_data;
        logic       en_q1;
        logic       en_q2;
        logic       en_prev;
        logic       strap_done;
        logic [CEM_NUM_GATED-1:0] run;
    } cem_state_t;
endpackage : cem_pkg

// ---- verif/cem_host.sv ----
// host model: drives the byte register port of the channel enable block
// assumes strobes are sampled on the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module cem_host
(
    input  wire logic       clk_sys,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        // idle bus shows junk, not the last value
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd
endmodule : cem_host
`default_nettype wire

// ---- verif/test_cem_regs.sv ----
// bench for the channel enable and mode registers
// assumes cem_host as the serial slave side and the bench as delay timers
`timescale 1ns/1ps
`default_nettype none
module test_cem_regs;
    import cem_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, alk = 1'b1, en_pin = 1'b1, wr, rd, dstart, m1, m10, s1, s10;
    logic [7:0] addr, wdata, rdata, got;
    logic [5:0] ddone = 6'h00, run;
    int errors = 0, checks_done = 0, cycles = 0, i;
    // addr, data, readback, {ch1 mode, ch10 mode, ch1 standby, ch10 standby}
    logic [27:0] rows [6] = '{28'h0D0303F, 28'h0D0101D, 28'h0E7E7E1, 28'h0E8181D, 28'h0D0202E, 28'h0F5500E};
    cem_host u_host (.clk_sys(clk_sys), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata));
    cem_regs u_dut (.clk_sys(clk_sys), .rst(rst), .variant_alkaline(alk), .en_pin(en_pin), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .delay_done(ddone),
        .delay_start(dstart), .chan_run(run), .ch1_mode_select(m1), .ch10_mode_select(m10),
        .ch1_standby_low_power(s1), .ch10_standby_low_power(s10));
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // runaway guard, the whole run is under a hundred cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        u_host.rd(CEM_ADDR_STANDBY, got);
        chk(got, 8'h02);
        u_host.rd(CEM_ADDR_CHAN_EN, got);
        chk(got, CEM_RST_CHAN_EN);
        for (i = 0; i < 6; i++)
        begin
            u_host.wr(rows[i][27:20], rows[i][19:12]);
            chk({4'h0, m1, m10, s1, s10}, {4'h0, rows[i][3:0]});
            u_host.rd(rows[i][27:20], got);
            chk(got, rows[i][11:4]);
        end
        en_pin = 1'b0;
        repeat (5) @(posedge clk_sys);
        u_host.wr(CEM_ADDR_CHAN_EN, 8'h00);
        u_host.rd(CEM_ADDR_CHAN_EN, got);
        chk(got, 8'hA1);
        en_pin = 1'b1;
        for (i = 0; i < 6 && dstart !== 1'b1; i++) @(posedge clk_sys) #1;
        chk({7'h00, dstart}, 8'h01);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({2'b00, run}, 8'h00);
        ddone = 6'h3F;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({2'b00, run}, 8'h10);
        // each bit maps to its own run output, one cycle after the write lands
        u_host.wr(CEM_ADDR_CHAN_EN, 8'h7E);
        @(posedge clk_sys) #1;
        chk({2'b00, run}, 8'h3F);
        u_host.wr(CEM_ADDR_CHAN_EN, 8'h40);
        @(posedge clk_sys) #1;
        chk({2'b00, run}, 8'h20);
        u_host.wr(CEM_ADDR_CHAN_EN, 8'h02);
        @(posedge clk_sys) #1;
        chk({2'b00, run}, 8'h01);
        // pin low while a channel runs: all off and the byte back to its reset value
        en_pin = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({2'b00, run}, 8'h00);
        u_host.rd(CEM_ADDR_CHAN_EN, got);
        chk(got, CEM_RST_CHAN_EN);
        en_pin = 1'b1;
        // second reset, lithium strap this time
        alk = 1'b0;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        u_host.rd(CEM_ADDR_STANDBY, got);
        chk(got, 8'h00);
        u_host.rd(CEM_ADDR_CHAN_EN, got);
        chk(got, CEM_RST_CHAN_EN);
        end_of_test();
    end
endmodule : test_cem_regs
`default_nettype wire
